// *** hdl/sfphr_map.svh ***
// Overview of operation
// (RL1) Standby whenever chip select is high and no self-timed operation runs.
// (RL2) In deep sleep every command is ignored except the resume opcode.
// (RL3) Opcode B9h enters deep sleep within its entry time after chip select rises.
// (RL4) Incomplete deep-sleep opcode or odd bit count aborts and keeps standby.
// (RL5) Power-up always starts in standby, never in a sleep mode.
// (RL6) Deep-sleep command is ignored while program or erase runs.
// (RL7) Opcode ABh leaves deep sleep within resume time after chip select rises.
// (RL8) Incomplete resume opcode or odd bit count leaves device in deep sleep.
// (RL9) Opcode 79h enters ultra sleep, ignored while program or erase runs.
// (RL10) In ultra sleep every command is ignored, the resume opcode too.
// (RL11) Ultra-sleep opcode not fully clocked in aborts back to standby.
// (RL12) Chip select low for the wake pulse time wakes within exit time.
// (RL13) A frame begun before the exit time elapses is ignored entirely.
// (RL14) Chip select held low for exit time wakes; an earlier bit is ignored.
// (RL15) Power cycling restores every internal register to its default.
// (RL16) Pause starts with chip select low when pin asserts during SCK low.
// (RL17) While paused, output floats and SI and SCK are ignored; WP still works.
// (RL18) Pause ends when pin releases during SCK low, else at next low phase.
// (RL19) Pause never suspends a running program or erase.
// (RL20) Chip select rising during pause aborts the frame and clears write enable.
// (RL21) Reset runs only when the reset-allow bit is one, regardless of write enable.
// (RL22) F0h then D0h terminates program or erase within reset time.
// (RL23) Reset keeps configuration and reset-allow bit, clears write-enable latch.
// (RL24) Missing reset byte or odd bit count performs no reset.
// (RL25) Opcode 31h plus data bit 4 sets reset-allow after write enable.
// (RL26) SCK rising edges counted per frame, checks made when chip select rises.
`ifndef SFPHR_MAP_SVH
`define SFPHR_MAP_SVH
`define SFPHR_CLK_MHZ 200
`define SFPHR_OP_DEEP 8'hB9
`define SFPHR_OP_RESUME 8'hAB
`define SFPHR_OP_ULTRA 8'h79
`define SFPHR_OP_WREN 8'h06
`define SFPHR_OP_WSR2 8'h31
`define SFPHR_OP_RST 8'hF0
`define SFPHR_OP_RST_OK 8'hD0
`define SFPHR_RSTALLOW_POS 4
`define SFPHR_ENTER_DEEP_SLEEP_TIME_NS 3000
`define SFPHR_RESUME_TIME_NS 8000
`define SFPHR_ENTER_ULTRA_SLEEP_TIME_NS 3000
`define SFPHR_ULTRA_WAKE_PULSE_TIME_NS 20
`define SFPHR_ULTRA_EXIT_TIME_NS 70000
`define SFPHR_RESET_TIME_NS 30000
`endif

// *** hdl/sfphr_pkg.sv ***
package sfphr_pkg;
	typedef enum logic [2:0] {
		SFPHR_STANDBY,
		SFPHR_DEEP_ENTER,
		SFPHR_DEEP,
		SFPHR_RESUME,
		SFPHR_ULTRA_ENTER,
		SFPHR_ULTRA,
		SFPHR_ULTRA_EXIT
	} sfphr_state_t;
endpackage

// *** hdl/sfphr_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sfphr_map.svh"
module sfphr_top #(
	parameter int ENTER_DEEP_SLEEP_TIME_NS = `SFPHR_ENTER_DEEP_SLEEP_TIME_NS,
	parameter int RESUME_TIME_NS = `SFPHR_RESUME_TIME_NS,
	parameter int ENTER_ULTRA_SLEEP_TIME_NS = `SFPHR_ENTER_ULTRA_SLEEP_TIME_NS,
	parameter int ULTRA_WAKE_PULSE_TIME_NS = `SFPHR_ULTRA_WAKE_PULSE_TIME_NS,
	parameter int ULTRA_EXIT_TIME_NS = `SFPHR_ULTRA_EXIT_TIME_NS,
	parameter int RESET_TIME_NS = `SFPHR_RESET_TIME_NS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic busy,
	output logic so_oe_n,
	output logic standby,
	output logic deep_sleep,
	output logic ultra_sleep,
	output logic paused,
	output logic write_protect,
	output logic write_enable_latch,
	output logic reset_allow_bit,
	output logic terminate_op,
	output logic frame_abort
);
	// longest times round down, least times round up, never below one
	localparam int EDPD_CYC = (ENTER_DEEP_SLEEP_TIME_NS * `SFPHR_CLK_MHZ
		/ 1000 < 1) ? 1 : ENTER_DEEP_SLEEP_TIME_NS * `SFPHR_CLK_MHZ / 1000;
	localparam int RDPD_CYC = (RESUME_TIME_NS * `SFPHR_CLK_MHZ
		/ 1000 < 1) ? 1 : RESUME_TIME_NS * `SFPHR_CLK_MHZ / 1000;
	localparam int EUDP_CYC = (ENTER_ULTRA_SLEEP_TIME_NS * `SFPHR_CLK_MHZ
		/ 1000 < 1) ? 1 : ENTER_ULTRA_SLEEP_TIME_NS * `SFPHR_CLK_MHZ / 1000;
	localparam int WAKE_CYC = (ULTRA_WAKE_PULSE_TIME_NS * `SFPHR_CLK_MHZ
		+ 999) / 1000 < 1 ? 1 :
		(ULTRA_WAKE_PULSE_TIME_NS * `SFPHR_CLK_MHZ + 999) / 1000;
	localparam int XUDP_CYC = (ULTRA_EXIT_TIME_NS * `SFPHR_CLK_MHZ
		/ 1000 < 1) ? 1 : ULTRA_EXIT_TIME_NS * `SFPHR_CLK_MHZ / 1000;
	localparam int RST_CYC = (RESET_TIME_NS * `SFPHR_CLK_MHZ
		/ 1000 < 1) ? 1 : RESET_TIME_NS * `SFPHR_CLK_MHZ / 1000;

	sfphr_pkg::sfphr_state_t state;
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic sck_q;
	logic cs_q;
	logic [31:0] timer;
	logic [31:0] low_cnt;
	logic [31:0] rst_cnt;
	logic [15:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] op;
	logic [7:0] arg;
	logic frame_ignore;
	logic wake_bit;

	wire logic cs_s = ~sync2[0];
	wire logic sck_s = sync2[1];
	wire logic si_s = sync2[2];
	wire logic hold_s = ~sync2[3];
	wire logic wp_s = ~sync2[4];
	wire logic cs_fall = cs_s & ~cs_q;
	wire logic frame_end = ~cs_s & cs_q;
	wire logic sck_rise = sck_s & ~sck_q & cs_s & ~paused;
	wire logic whole = bit_cnt[2:0] == 3'h0;
	wire logic has1 = whole && bit_cnt >= 16'd8;
	wire logic has2 = whole && bit_cnt >= 16'd16;
	wire logic eval = frame_end && !frame_ignore && !hold_s;
	wire logic in_standby = state == sfphr_pkg::SFPHR_STANDBY;
	wire logic wake_ok = low_cnt >= 32'(WAKE_CYC);

	// pins are asynchronous to clk_sys
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync1 <= 5'h1D;
			sync2 <= 5'h1D;
		end else begin
			sync1 <= {wp_n, hold_n, si, sck, cs_n};
			sync2 <= sync1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sck_q <= 1'b0;
			cs_q <= 1'b0;
		end else begin
			sck_q <= sck_s;
			cs_q <= cs_s;
		end
	end

	// pause follows pin only while SCK is low
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			paused <= 1'b0;
		end else if (!cs_s) begin
			paused <= 1'b0;
		end else if (!sck_s) begin
			paused <= hold_s; // RL16 RL18
		end
	end

	// frame shifter; paused frames see no SCK or SI
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 16'h0000;
			shreg <= 8'h00;
			op <= 8'h00;
			arg <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt <= 16'h0000; // RL26
			op <= 8'h00;
			arg <= 8'h00;
		end else if (sck_rise) begin // RL17
			shreg <= {shreg[6:0], si_s};
			if (bit_cnt != 16'hFFFF) begin
				bit_cnt <= bit_cnt + 16'h0001; // RL26
			end
			if (bit_cnt == 16'd7) begin
				op <= {shreg[6:0], si_s};
			end
			if (bit_cnt == 16'd15) begin
				arg <= {shreg[6:0], si_s};
			end
		end
	end

	// frames started outside standby or deep sleep are dead, unless chip select stays low for the ultra exit time in ultra sleep with no SCK edge
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frame_ignore <= 1'b0;
		end else if (cs_fall) begin
			frame_ignore <= !(in_standby ||
				state == sfphr_pkg::SFPHR_DEEP); // RL13 RL10
		end else if (state == sfphr_pkg::SFPHR_ULTRA && cs_s &&
			low_cnt >= 32'(XUDP_CYC) && !wake_bit) begin
			frame_ignore <= 1'b0; // RL14
		end
	end

	// chip-select low time, used for waking from ultra sleep
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= 32'h00000000;
			wake_bit <= 1'b0;
		end else if (cs_fall) begin
			low_cnt <= 32'h00000000;
			wake_bit <= 1'b0;
		end else if (cs_s) begin
			if (low_cnt != 32'hFFFFFFFF) begin
				low_cnt <= low_cnt + 32'h00000001;
			end
			if (sck_rise) begin
				wake_bit <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= sfphr_pkg::SFPHR_STANDBY; // RL5 RL15
			timer <= 32'h00000000;
		end else begin
			case (state)
			sfphr_pkg::SFPHR_STANDBY: begin
				if (eval && has1 && !busy) begin // RL6 RL9
					if (op == `SFPHR_OP_DEEP) begin // RL3 RL4
						state <= sfphr_pkg::SFPHR_DEEP_ENTER;
						timer <= 32'(EDPD_CYC);
					end else if (op == `SFPHR_OP_ULTRA) begin // RL11
						state <= sfphr_pkg::SFPHR_ULTRA_ENTER;
						timer <= 32'(EUDP_CYC);
					end
				end
			end
			sfphr_pkg::SFPHR_DEEP: begin
				if (eval && has1 && op == `SFPHR_OP_RESUME) begin // RL7 RL8
					state <= sfphr_pkg::SFPHR_RESUME;
					timer <= 32'(RDPD_CYC);
				end
			end
			sfphr_pkg::SFPHR_ULTRA: begin
				// low time and wake bit still hold the last frame's
				if (cs_s && !cs_fall &&
					(wake_bit || low_cnt >= 32'(XUDP_CYC))) begin
					state <= sfphr_pkg::SFPHR_ULTRA_EXIT; // RL14
					timer <= 32'h00000001;
					if (wake_bit) begin
						timer <= 32'(XUDP_CYC);
					end
				end else if (frame_end && wake_ok) begin // RL12
					state <= sfphr_pkg::SFPHR_ULTRA_EXIT;
					timer <= 32'(XUDP_CYC);
				end
			end
			sfphr_pkg::SFPHR_DEEP_ENTER,
			sfphr_pkg::SFPHR_RESUME,
			sfphr_pkg::SFPHR_ULTRA_ENTER,
			sfphr_pkg::SFPHR_ULTRA_EXIT: begin
				if (timer <= 32'h00000001) begin
					timer <= 32'h00000000;
					if (state == sfphr_pkg::SFPHR_DEEP_ENTER) begin
						state <= sfphr_pkg::SFPHR_DEEP;
					end else if (state == sfphr_pkg::SFPHR_ULTRA_ENTER) begin
						state <= sfphr_pkg::SFPHR_ULTRA;
					end else begin
						state <= sfphr_pkg::SFPHR_STANDBY;
					end
				end else begin
					timer <= timer - 32'h00000001;
				end
			end
			default: begin
				state <= sfphr_pkg::SFPHR_STANDBY;
				timer <= 32'h00000000;
			end
			endcase
		end
	end

	// write enable and reset-allow bit
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			write_enable_latch <= 1'b0;
			reset_allow_bit <= 1'b0;
		end else if (frame_end && hold_s && cs_q) begin
			write_enable_latch <= 1'b0; // RL20
		end else if (eval && in_standby) begin
			if (has1 && op == `SFPHR_OP_WREN) begin
				write_enable_latch <= 1'b1;
			end else if (op == `SFPHR_OP_WSR2) begin
				write_enable_latch <= 1'b0; // RL25
				if (has2 && write_enable_latch) begin
					reset_allow_bit <= arg[`SFPHR_RSTALLOW_POS]; // RL25
				end
			end else if (has2 && op == `SFPHR_OP_RST &&
				arg == `SFPHR_OP_RST_OK && reset_allow_bit) begin
				write_enable_latch <= 1'b0; // RL23
			end
		end
	end

	// reset runs independent of write enable; a frame that ends with hold asserted runs none
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_cnt <= 32'h00000000;
			terminate_op <= 1'b0;
		end else begin
			terminate_op <= 1'b0;
			if (eval && in_standby && has2 && op == `SFPHR_OP_RST &&
				arg == `SFPHR_OP_RST_OK && reset_allow_bit) begin // RL21 RL22 RL24
				rst_cnt <= 32'(RST_CYC);
			end else if (rst_cnt != 32'h00000000) begin
				rst_cnt <= rst_cnt - 32'h00000001;
				// a program that already ended needs no terminate
				terminate_op <= busy && rst_cnt == 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			frame_abort <= 1'b0;
		end else begin
			frame_abort <= frame_end && hold_s; // RL20
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			so_oe_n <= 1'b1;
			standby <= 1'b1;
			deep_sleep <= 1'b0;
			ultra_sleep <= 1'b0;
			write_protect <= 1'b0;
		end else begin
			so_oe_n <= !cs_s || paused || frame_ignore ||
				!(in_standby); // RL17 RL2 RL10
			standby <= in_standby && !cs_s && !busy; // RL1 RL19
			deep_sleep <= state == sfphr_pkg::SFPHR_DEEP;
			ultra_sleep <= state == sfphr_pkg::SFPHR_ULTRA;
			write_protect <= wp_s; // RL17
		end
	end

	chk_deep_entry: assert property (@(posedge clk_sys) // RL3
		disable iff (!reset_n)
		eval && in_standby && has1 && op == `SFPHR_OP_DEEP && !busy
		|=> state == sfphr_pkg::SFPHR_DEEP_ENTER)
		else $error("deep sleep entry missed");
	chk_deep_busy: assert property (@(posedge clk_sys) // RL6
		disable iff (!reset_n)
		in_standby && busy |=> state != sfphr_pkg::SFPHR_DEEP_ENTER
		&& state != sfphr_pkg::SFPHR_ULTRA_ENTER)
		else $error("sleep entered during busy");
	chk_deep_locked: assert property (@(posedge clk_sys) // RL2
		disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_DEEP && !(frame_end && has1 &&
		op == `SFPHR_OP_RESUME) |=> state == sfphr_pkg::SFPHR_DEEP)
		else $error("deep sleep left without resume");
	chk_ultra_locked: assert property (@(posedge clk_sys) // RL10
		disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_ULTRA && !cs_s && !frame_end
		|=> state == sfphr_pkg::SFPHR_ULTRA)
		else $error("ultra sleep left without chip select");
	chk_pause_float: assert property (@(posedge clk_sys) // RL17
		disable iff (!reset_n)
		paused |=> so_oe_n)
		else $error("output driven while paused");
	chk_pause_start: assert property (@(posedge clk_sys) // RL16
		disable iff (!reset_n)
		$rose(paused) |-> $past(!sck_s) && $past(hold_s))
		else $error("pause began outside SCK low");
	chk_reset_allow: assert property (@(posedge clk_sys) // RL21 RL23
		disable iff (!reset_n)
		$rose(rst_cnt != 32'h00000000) |-> reset_allow_bit
		&& !write_enable_latch)
		else $error("reset ran while not allowed");
	chk_hold_abort: assert property (@(posedge clk_sys) // RL20
		disable iff (!reset_n)
		frame_end && hold_s |=> !write_enable_latch ##0 frame_abort)
		else $error("hold abort left write enable set");
	chk_short_frame: assert property (@(posedge clk_sys) // RL4
		disable iff (!reset_n)
		in_standby && frame_end && !whole |=> in_standby)
		else $error("sleep begun on a broken byte");
	chk_resume_short: assert property (@(posedge clk_sys) // RL8
		disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_DEEP && frame_end && !has1
		|=> state == sfphr_pkg::SFPHR_DEEP)
		else $error("resume taken from a broken byte");
	chk_ultra_short: assert property (@(posedge clk_sys) // RL11
		disable iff (!reset_n)
		in_standby && frame_end && bit_cnt < 16'd8
		|=> in_standby)
		else $error("ultra sleep begun on a short opcode");
	chk_exit_ignore: assert property (@(posedge clk_sys) // RL13
		disable iff (!reset_n)
		cs_fall && state == sfphr_pkg::SFPHR_ULTRA_EXIT
		|=> frame_ignore)
		else $error("frame taken before ultra exit ended");
	chk_low_wake: assert property (@(posedge clk_sys) // RL14
		disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_ULTRA && cs_s && !cs_fall && !wake_bit
		&& low_cnt >= 32'(XUDP_CYC) |=> !frame_ignore
		&& state == sfphr_pkg::SFPHR_ULTRA_EXIT)
		else $error("chip-select-low wake missed");
	chk_early_bit: assert property (@(posedge clk_sys) // RL14
		disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_ULTRA && cs_s && !cs_fall && wake_bit
		|=> frame_ignore && state == sfphr_pkg::SFPHR_ULTRA_EXIT)
		else $error("early bit did not wake or was taken");
	chk_reset_gate: assert property (@(posedge clk_sys) // RL21
		disable iff (!reset_n)
		!reset_allow_bit && rst_cnt == 32'h00000000
		|=> rst_cnt == 32'h00000000)
		else $error("reset loaded while not allowed");
	chk_reset_short: assert property (@(posedge clk_sys) // RL24
		disable iff (!reset_n)
		frame_end && !has2 && rst_cnt == 32'h00000000
		|=> rst_cnt == 32'h00000000)
		else $error("reset loaded from a short frame");
	chk_allow_write: assert property (@(posedge clk_sys) // RL25
		disable iff (!reset_n)
		$changed(reset_allow_bit) |-> $past(write_enable_latch)
		&& $past(eval) && $past(op) == `SFPHR_OP_WSR2)
		else $error("reset-allow bit changed without write");
	chk_latch_set: assert property (@(posedge clk_sys) // RL25
		disable iff (!reset_n)
		$rose(write_enable_latch) |-> $past(eval)
		&& $past(op) == `SFPHR_OP_WREN)
		else $error("write enable set without its opcode");
	chk_standby_level: assert property (@(posedge clk_sys) // RL1
		disable iff (!reset_n)
		in_standby && !cs_s && !busy |=> standby)
		else $error("standby not shown while idle");
	cov_deep: cover property (@(posedge clk_sys) disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_DEEP ##1 state == sfphr_pkg::SFPHR_RESUME);
	cov_ultra: cover property (@(posedge clk_sys) disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_ULTRA ##1
		state == sfphr_pkg::SFPHR_ULTRA_EXIT);
	cov_reset: cover property (@(posedge clk_sys) disable iff (!reset_n)
		terminate_op);
	cov_pause: cover property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(paused) && cs_s);
	cov_low_wake: cover property (@(posedge clk_sys) disable iff (!reset_n)
		state == sfphr_pkg::SFPHR_ULTRA && cs_s && !wake_bit ##1
		state == sfphr_pkg::SFPHR_ULTRA_EXIT);
endmodule
`default_nettype wire

// *** tb/sfphr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfphr_host (
	input wire logic clk_sys,
	input wire logic paused,
	input wire logic so_oe_n,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic hold_n
);
	logic saw_float;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		saw_float = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// mode 0, msb first; sck stands low outside frames
	task automatic frame(input logic [15:0] d, input int nb, input int pre,
		input int hold_at, input bit let_go);
		cs_n = 1'b0;
		tick(pre);
		for (int i = 0; i < nb; i++) begin
			si = d[15-i];
			if (i == hold_at) begin
				hold_n = 1'b0;
				tick(8);
				// extra edges while paused must not count
				repeat (2) begin
					sck = 1'b1;
					si = ~si;
					tick(8);
					sck = 1'b0;
					tick(8);
				end
				saw_float = (paused === 1'b1) && (so_oe_n === 1'b1);
				if (!let_go) break;
				hold_n = 1'b1;
				si = d[15-i];
			end
			tick(8);
			sck = 1'b1;
			tick(8);
			sck = 1'b0;
		end
		tick(4);
		cs_n = 1'b1;
		// released line must not keep the last bit
		si = ~si;
		tick(4);
		hold_n = 1'b1;
		tick(40);
	endtask
endmodule
`default_nettype wire

// *** tb/spi_flash_power_hold_reset_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module spi_flash_power_hold_reset_tb;
	localparam int EDP = 100;
	localparam int XUD = 200;
	logic clk_sys, reset_n, busy, wp_n, cs_n, sck, si, hold_n;
	logic so_oe_n, standby, deep_sleep, ultra_sleep, paused, write_protect;
	logic write_enable_latch, reset_allow_bit, terminate_op, frame_abort;
	logic [4:0] st;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_term = 0;
	int n_abort = 0;
	int t0;
	assign st = {standby, deep_sleep, ultra_sleep, write_enable_latch,
		reset_allow_bit};
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// short times keep the run small; cycle figures above follow them
	sfphr_top #(.ENTER_DEEP_SLEEP_TIME_NS(500), .RESUME_TIME_NS(500),
		.ENTER_ULTRA_SLEEP_TIME_NS(500),
		.ULTRA_EXIT_TIME_NS(1000), .RESET_TIME_NS(500)) DUT (
		.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sck(sck),
		.si(si), .hold_n(hold_n), .wp_n(wp_n), .busy(busy),
		.so_oe_n(so_oe_n), .standby(standby), .deep_sleep(deep_sleep),
		.ultra_sleep(ultra_sleep), .paused(paused),
		.write_protect(write_protect),
		.write_enable_latch(write_enable_latch),
		.reset_allow_bit(reset_allow_bit), .terminate_op(terminate_op),
		.frame_abort(frame_abort));
	sfphr_host host (.clk_sys(clk_sys), .paused(paused), .so_oe_n(so_oe_n),
		.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [4:0] got,
		input logic [4:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic op(input logic [7:0] a, input logic [7:0] b, input int nb,
		input int w);
		host.frame({a, b}, nb, 4, -1, 1'b0);
		tick(w);
	endtask
	// pulses are one cycle wide, so count them where they stand
	always @(posedge clk_sys) begin
		cyc++;
		if (terminate_op === 1'b1) n_term++;
		if (frame_abort === 1'b1) n_abort++;
		if (cyc == 60000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		reset_n = 1'b0;
		busy = 1'b0;
		wp_n = 1'b1;
		tick(3);
		reset_n = 1'b1;
		tick(4);
		chk("reset state", st, 5'h10);
		chk("output float", {4'h0, so_oe_n}, 5'h01);
		wp_n = 1'b0;
		tick(4);
		chk("write protect", {4'h0, write_protect}, 5'h01);
		wp_n = 1'b1;
		$display("test reset done");
		op(8'hB9, 8'h00, 7, EDP + 20);
		chk("short deep entry", st, 5'h10);
		op(8'hB9, 8'h00, 16, EDP + 20);
		chk("deep entry", st, 5'h08);
		op(8'h06, 8'h00, 8, 20);
		chk("command in deep", st, 5'h08);
		op(8'hAB, 8'h00, 9, EDP + 20);
		chk("odd resume", st, 5'h08);
		op(8'hAB, 8'h00, 8, EDP + 20);
		chk("resume", st, 5'h10);
		$display("test deep done");
		busy = 1'b1;
		t0 = n_term;
		op(8'hF0, 8'hD0, 16, EDP + 20);
		chk("reset disabled", 5'(n_term - t0), 5'h00);
		op(8'hB9, 8'h00, 8, EDP + 20);
		chk("deep while busy", st, 5'h00);
		op(8'h79, 8'h00, 8, EDP + 20);
		chk("ultra while busy", st, 5'h00);
		busy = 1'b0;
		tick(4);
		chk("standby", st, 5'h10);
		op(8'h31, 8'h10, 16, 20);
		chk("no write enable", st, 5'h10);
		op(8'h06, 8'h00, 8, 20);
		chk("write enable", st, 5'h12);
		op(8'h31, 8'h10, 16, 20);
		chk("reset allow", st, 5'h11);
		$display("test reset allow done");
		busy = 1'b1;
		t0 = n_term;
		op(8'hF0, 8'hD0, 12, EDP + 20);
		chk("partial reset", 5'(n_term - t0), 5'h00);
		op(8'h06, 8'h00, 8, 20);
		op(8'hF0, 8'hD0, 16, EDP + 20);
		chk("reset pulse", 5'(n_term - t0), 5'h01);
		chk("after reset", st, 5'h01);
		busy = 1'b0;
		tick(4);
		$display("test software reset done");
		op(8'h79, 8'h00, 4, EDP + 20);
		chk("short ultra", st, 5'h11);
		op(8'h79, 8'h00, 8, EDP + 20);
		chk("ultra entry", st, 5'h05);
		op(8'h06, 8'h00, 8, XUD + 40);
		chk("toggle wake", st, 5'h11);
		op(8'h79, 8'h00, 8, EDP + 20);
		host.frame(16'h0000, 0, 8, -1, 1'b0);
		op(8'h06, 8'h00, 8, XUD + 40);
		chk("early frame", st, 5'h11);
		op(8'h79, 8'h00, 8, EDP + 20);
		host.frame(16'h0600, 8, XUD + 20, -1, 1'b0);
		tick(20);
		chk("low wake", st, 5'h13);
		$display("test ultra done");
		t0 = n_abort;
		host.frame(16'h0600, 8, 4, 3, 1'b0);
		tick(20);
		chk("pause float", {4'h0, host.saw_float}, 5'h01);
		chk("pause abort", 5'(n_abort - t0), 5'h01);
		chk("abort clears latch", st, 5'h11);
		host.frame(16'h0600, 8, 4, 3, 1'b1);
		tick(20);
		chk("resumed frame", st, 5'h13);
		$display("test pause done");
		op(8'h79, 8'h00, 8, EDP + 20);
		chk("ultra before power cycle", st, 5'h07);
		reset_n = 1'b0;
		tick(3);
		reset_n = 1'b1;
		tick(4);
		chk("power cycle", st, 5'h10);
		$display("test power cycle done");
		print_verdict();
	end
endmodule
`default_nettype wire
